// *** hw/mfd_core.sv ***
/*
  move-family execute unit behind an ahb-lite slave: software writes an opcode
  and a source operand, starts execution, and reads result, flags and status.
  assumes one ahb-lite master, single word transfers, and synchronous reset.
*/
// Decided for this implementation: the address map and the AHB-Lite interface to the registers.
// Contract
// RULE1 - a general move accepts only data-alterable destinations.
// RULE2 - a general move accepts every source mode, address register and pc-relative included.
// RULE3 - a byte move from an address register is illegal and not performed.
// RULE4 - the load-address op takes its target register from the dedicated field.
// RULE5 - load-address size 11 is word sign-extended to 32 bits, 10 is long, flags untouched.
// RULE6 - the load-address op accepts every source mode.
// RULE7 - reading the flag byte gives it zero-extended to a word, flags untouched.
// RULE8 - reading the flag byte allows only data-alterable destinations.
// RULE9 - reading the flag byte is always a word access.
// RULE10 - writing the flag byte uses the source low byte and keeps the upper state byte.
// RULE11 - writing the flag byte loads x, n, z, v, c from source bits 4 to 0.
// RULE12 - a general move sets n and z from the data, clears v and c, keeps x.
// RULE13 - the move size field is 01 byte, 11 word, 10 long.
// RULE14 - writing the flag byte accepts data-mode sources only, immediate included.
// RULE15 - a disallowed mode or size combination is flagged illegal instead of run.
`timescale 1ns/1ps
`default_nettype none
module mfd_core (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic illegal_out,
  output logic irq_out
);
  import mfd_pkg::*;

  logic [15:0] opcode_r;
  logic [31:0] src_r;
  logic [31:0] result_r;
  logic [2:0] dst_reg_r;
  logic [4:0] flags_r;
  logic [7:0] upper_r;
  logic [1:0] irq_stat_r;
  logic [1:0] irq_mask_r;
  logic illegal_r;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [31:0] rdata_r;
  mfd_op_t last_op_r;

  logic dec_move;
  logic dec_load;
  logic dec_fread;
  logic dec_fwrite;
  logic dec_illegal;
  logic [1:0] dec_size;
  logic [2:0] dec_dst;

  mfd_decode u_dec (
    .opcode_in(opcode_r),
    .is_move_out(dec_move),
    .is_load_areg_out(dec_load),
    .is_flags_read_out(dec_fread),
    .is_flags_write_out(dec_fwrite),
    .illegal_out(dec_illegal),
    .size_out(dec_size),
    .dst_reg_out(dec_dst)
  );

  // bus decode: zero wait states, writes land in the data phase
  wire logic addr_phase = hsel_in && hready_in && htrans_in[1];
  wire logic rd_phase = addr_phase && !hwrite_in;
  wire logic wr_now = wr_pend_r;
  wire logic start = wr_now && (wr_addr_r == OFS_CTRL) && hwdata_in[0];
  wire logic run = start && !dec_illegal;

  // sized move data and its sign for flags
  wire logic [31:0] move_data = (dec_size == SZ_BYTE) ? {24'h0, src_r[7:0]}
    : (dec_size == SZ_WORD) ? {16'h0, src_r[15:0]} : src_r;
  wire logic move_neg = (dec_size == SZ_BYTE) ? src_r[7]
    : (dec_size == SZ_WORD) ? src_r[15] : src_r[31];
  // RULE5 sign-extend word source
  wire logic [31:0] load_data = (dec_size == SZ_WORD) ? {{16{src_r[15]}}, src_r[15:0]} : src_r;
  // RULE7 zero-extended flag byte
  wire logic [31:0] fread_data = {24'h0, 3'h0, flags_r};
  wire logic [31:0] result_nxt = dec_move ? move_data : dec_load ? load_data : fread_data;

  // RULE12 n and z from data, v c cleared
  wire logic [4:0] move_flags = {flags_r[FLAG_X], move_neg, (move_data == 32'h0), 2'h0};
  // RULE11 flags from source bits
  // RULE10 only the low byte is used
  wire logic [4:0] fwrite_flags = {src_r[FLAG_X], src_r[FLAG_N], src_r[FLAG_Z],
    src_r[FLAG_V], src_r[FLAG_C]};
  wire logic [4:0] flags_nxt = (run && dec_move) ? move_flags
    : (run && dec_fwrite) ? fwrite_flags : flags_r;

  mfd_op_t op_nxt;
  assign op_nxt = !run ? last_op_r : dec_move ? OP_MOVE : dec_load ? OP_LOAD_AREG : OP_FLAGS_RW;

  wire logic [1:0] events = {start && dec_illegal, run};
  wire logic [1:0] irq_clear = (wr_now && wr_addr_r == OFS_IRQ_STAT) ? hwdata_in[1:0] : 2'h0;
  // set wins over a write-one clear in the same cycle
  wire logic [1:0] irq_stat_nxt = (irq_stat_r & ~irq_clear) | events;

  wire logic [7:0] rd_addr = haddr_in[7:0];
  wire logic [31:0] rd_mux =
    (rd_addr == OFS_OPCODE) ? {16'h0, opcode_r} :
    (rd_addr == OFS_SRC) ? src_r :
    (rd_addr == OFS_RESULT) ? result_r :
    (rd_addr == OFS_STATE) ? {16'h0, upper_r, 3'h0, flags_r} :
    (rd_addr == OFS_IRQ_STAT) ? {30'h0, irq_stat_r} :
    (rd_addr == OFS_IRQ_MASK) ? {30'h0, irq_mask_r} :
    (rd_addr == OFS_STATUS) ? {24'h0, last_op_r, 1'h0, dst_reg_r} : 32'h0;

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      rdata_r <= 32'h0;
    end
    else
    begin
      wr_pend_r <= addr_phase && hwrite_in;
      wr_addr_r <= haddr_in[7:0];
      rdata_r <= rd_phase ? rd_mux : rdata_r;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      opcode_r <= 16'h0;
      src_r <= 32'h0;
      irq_mask_r <= 2'h0;
    end
    else if (wr_now)
    begin
      opcode_r <= (wr_addr_r == OFS_OPCODE) ? hwdata_in[15:0] : opcode_r;
      src_r <= (wr_addr_r == OFS_SRC) ? hwdata_in : src_r;
      irq_mask_r <= (wr_addr_r == OFS_IRQ_MASK) ? hwdata_in[1:0] : irq_mask_r;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      flags_r <= FLAGS_RST;
      upper_r <= UPPER_RST;
      result_r <= 32'h0;
      dst_reg_r <= 3'h0;
      illegal_r <= 1'b0;
      irq_stat_r <= 2'h0;
      last_op_r <= OP_NONE;
    end
    else
    begin
      flags_r <= flags_nxt;
      // upper state byte is never written by these ops
      upper_r <= upper_r;
      // RULE4 latch target register
      result_r <= (run && !dec_fwrite) ? result_nxt : result_r;
      dst_reg_r <= run ? dec_dst : dst_reg_r;
      // RULE15 illegal pulse to exceptions
      illegal_r <= start && dec_illegal;
      irq_stat_r <= irq_stat_nxt;
      last_op_r <= op_nxt;
    end
  end

  assign hrdata_out = rdata_r;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign illegal_out = illegal_r;
  assign irq_out = |(irq_stat_r & irq_mask_r);

  // RULE15 illegal start runs nothing
  a_illegal_noexec: assert property (@(posedge clk_in) disable iff (srst_in) // RULE15
    start && dec_illegal |=> flags_r == $past(flags_r) && illegal_out)
    else $error("illegal opcode executed");
  // RULE12 move flag update
  a_move_flags: assert property (@(posedge clk_in) disable iff (srst_in) // RULE12
    run && dec_move |=> !flags_r[FLAG_V] && !flags_r[FLAG_C]
      && flags_r[FLAG_X] == $past(flags_r[FLAG_X]))
    else $error("move flags wrong");
  // RULE11 flag write source bits
  a_flag_write: assert property (@(posedge clk_in) disable iff (srst_in) // RULE11
    run && dec_fwrite |=> flags_r == $past(src_r[4:0]))
    else $error("flag write wrong");
  // RULE5 load keeps flags
  a_load_flags: assert property (@(posedge clk_in) disable iff (srst_in) // RULE5
    run && dec_load |=> $stable(flags_r))
    else $error("load changed flags");
  // RULE5 sign extension
  a_load_sext: assert property (@(posedge clk_in) disable iff (srst_in) // RULE5
    run && dec_load && dec_size == SZ_WORD |=> result_r[31:16] == {16{result_r[15]}})
    else $error("no sign extension");
  // RULE7 zero extension
  a_read_zext: assert property (@(posedge clk_in) disable iff (srst_in) // RULE7
    run && dec_fread |=> result_r[31:5] == 27'h0 && $stable(flags_r))
    else $error("flag read not zero-extended");
  // RULE3 byte from address reg
  a_byte_areg: assert property (@(posedge clk_in) disable iff (srst_in) // RULE3
    dec_move && dec_size == SZ_BYTE && opcode_r[5:3] == MODE_AREG |-> dec_illegal)
    else $error("byte from address reg legal");
  // RULE1 bad destination
  a_move_dst: assert property (@(posedge clk_in) disable iff (srst_in) // RULE1
    dec_move && opcode_r[8:6] == MODE_EXT && opcode_r[11:9] == EXT_IMM |-> dec_illegal)
    else $error("immediate destination legal");
  // RULE10 upper byte kept
  a_upper_kept: assert property (@(posedge clk_in) disable iff (srst_in) // RULE10
    run && dec_fwrite |=> $stable(upper_r))
    else $error("upper byte changed");
  a_irq_level: assert property (@(posedge clk_in) disable iff (srst_in)
    events[0] && irq_mask_r[0] |=> irq_out)
    else $error("irq missed");
  // RULE12 zero flag from data
  a_move_zero: assert property (@(posedge clk_in) disable iff (srst_in) // RULE12
    run && dec_move |=> flags_r[FLAG_Z] == (result_r == 32'h0))
    else $error("move zero flag wrong");
  // RULE12 byte sign flag
  a_neg_byte: assert property (@(posedge clk_in) disable iff (srst_in) // RULE12
    run && dec_move && dec_size == SZ_BYTE |=> flags_r[FLAG_N] == result_r[7])
    else $error("byte negative flag wrong");
  // RULE12 word sign flag
  a_neg_word: assert property (@(posedge clk_in) disable iff (srst_in) // RULE12
    run && dec_move && dec_size == SZ_WORD |=> flags_r[FLAG_N] == result_r[15])
    else $error("word negative flag wrong");
  // RULE12 long sign flag
  a_neg_long: assert property (@(posedge clk_in) disable iff (srst_in) // RULE12
    run && dec_move && dec_size == SZ_LONG |=> flags_r[FLAG_N] == result_r[31])
    else $error("long negative flag wrong");
  // RULE13 byte move width
  a_byte_move: assert property (@(posedge clk_in) disable iff (srst_in) // RULE13
    run && dec_move && dec_size == SZ_BYTE |=> result_r == {24'h0, $past(src_r[7:0])})
    else $error("byte move data wrong");
  // RULE13 word move width
  a_word_move: assert property (@(posedge clk_in) disable iff (srst_in) // RULE13
    run && dec_move && dec_size == SZ_WORD |=> result_r == {16'h0, $past(src_r[15:0])})
    else $error("word move data wrong");
  // RULE13 long move width
  a_long_move: assert property (@(posedge clk_in) disable iff (srst_in) // RULE13
    run && dec_move && dec_size == SZ_LONG |=> result_r == $past(src_r))
    else $error("long move data wrong");
  // RULE5 long load whole
  a_load_long: assert property (@(posedge clk_in) disable iff (srst_in) // RULE5
    run && dec_load && dec_size == SZ_LONG |=> result_r == $past(src_r))
    else $error("long load data wrong");
  // RULE5 word load extended
  a_load_word: assert property (@(posedge clk_in) disable iff (srst_in) // RULE5
    run && dec_load && dec_size == SZ_WORD |=> result_r[15:0] == $past(src_r[15:0])
      && result_r[16] == $past(src_r[15]))
    else $error("word load data wrong");
  // RULE5 byte load refused
  a_load_byte: assert property (@(posedge clk_in) disable iff (srst_in) // RULE5
    dec_load && dec_size == SZ_BYTE |-> dec_illegal)
    else $error("byte load accepted");
  // RULE4 target register field
  a_dst_field: assert property (@(posedge clk_in) disable iff (srst_in) // RULE4
    run |=> dst_reg_r == $past(opcode_r[11:9]))
    else $error("target register wrong");
  // RULE7 flag byte read
  a_read_flags: assert property (@(posedge clk_in) disable iff (srst_in) // RULE7
    run && dec_fread |=> result_r[4:0] == $past(flags_r))
    else $error("flag read data wrong");
  // RULE9 word access
  a_read_word: assert property (@(posedge clk_in) disable iff (srst_in) // RULE9
    dec_fread |-> dec_size == SZ_WORD)
    else $error("flag read not word sized");
  // RULE8 address reg destination
  a_read_areg: assert property (@(posedge clk_in) disable iff (srst_in) // RULE8
    dec_fread && opcode_r[5:3] == MODE_AREG |-> dec_illegal)
    else $error("flag read to address reg legal");
  // RULE8 pc-relative destination
  a_read_pcdst: assert property (@(posedge clk_in) disable iff (srst_in) // RULE8
    dec_fread && opcode_r[5:3] == MODE_EXT && opcode_r[2:0] == EXT_PC_DISP |-> dec_illegal)
    else $error("flag read to pc-relative legal");
  // RULE14 address reg source
  a_write_areg: assert property (@(posedge clk_in) disable iff (srst_in) // RULE14
    dec_fwrite && opcode_r[5:3] == MODE_AREG |-> dec_illegal)
    else $error("flag write from address reg legal");
  // RULE14 immediate source allowed
  a_write_imm: assert property (@(posedge clk_in) disable iff (srst_in) // RULE14
    dec_fwrite && opcode_r[5:3] == MODE_EXT && opcode_r[2:0] == EXT_IMM |-> !dec_illegal)
    else $error("flag write from immediate refused");
  // RULE2 address reg source
  a_move_areg: assert property (@(posedge clk_in) disable iff (srst_in) // RULE2
    dec_move && dec_size == SZ_WORD && opcode_r[5:3] == MODE_AREG
      && opcode_r[8:6] == MODE_DREG |-> !dec_illegal)
    else $error("word move from address reg refused");
  // RULE1 pc-relative destination
  a_move_pcdst: assert property (@(posedge clk_in) disable iff (srst_in) // RULE1
    dec_move && opcode_r[8:6] == MODE_EXT && opcode_r[11:9] == EXT_PC_DISP |-> dec_illegal)
    else $error("pc-relative destination legal");
  // RULE3 refused op leaves state
  a_illegal_keep: assert property (@(posedge clk_in) disable iff (srst_in) // RULE3
    start && dec_illegal |=> $stable(result_r) && $stable(dst_reg_r) && irq_stat_r[1])
    else $error("refused opcode changed state");

  c_move: cover property (@(posedge clk_in) run && dec_move);
  c_load: cover property (@(posedge clk_in) run && dec_load);
  c_fwrite: cover property (@(posedge clk_in) run && dec_fwrite);
  c_illegal: cover property (@(posedge clk_in) start && dec_illegal);
  c_fread: cover property (@(posedge clk_in) run && dec_fread);
endmodule : mfd_core
`default_nettype wire

// *** hw/mfd_pkg.sv ***
/*
  shared constants for the move-family decoder: opcode fields, mode codes,
  size codes, flag positions and register offsets of the bus slave.
  assumes nothing of its surroundings.
*/
package mfd_pkg;
  localparam logic [2:0] MODE_DREG = 3'h0;
  localparam logic [2:0] MODE_AREG = 3'h1;
  localparam logic [2:0] MODE_IND_LO = 3'h2;
  localparam logic [2:0] MODE_IND_HI = 3'h6;
  localparam logic [2:0] MODE_EXT = 3'h7;
  localparam logic [2:0] EXT_ABS_W = 3'h0;
  localparam logic [2:0] EXT_ABS_L = 3'h1;
  localparam logic [2:0] EXT_PC_DISP = 3'h2;
  localparam logic [2:0] EXT_PC_IDX = 3'h3;
  localparam logic [2:0] EXT_IMM = 3'h4;
  localparam logic [1:0] SZ_BYTE = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;
  localparam logic [1:0] SZ_WORD = 2'h3;
  localparam logic [1:0] TOP_MOVE = 2'h0;
  localparam logic [9:0] OPC_FROM_FLAGS = 10'h10b;
  localparam logic [9:0] OPC_TO_FLAGS = 10'h113;
  localparam int FLAG_X = 4;
  localparam int FLAG_N = 3;
  localparam int FLAG_Z = 2;
  localparam int FLAG_V = 1;
  localparam int FLAG_C = 0;
  localparam logic [4:0] FLAGS_RST = 5'h00;
  localparam logic [7:0] UPPER_RST = 8'h00;
  localparam logic [7:0] OFS_OPCODE = 8'h00;
  localparam logic [7:0] OFS_SRC = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_RESULT = 8'h0c;
  localparam logic [7:0] OFS_STATE = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [1:0] EV_DONE = 2'h1;
  localparam logic [1:0] EV_ILLEGAL = 2'h2;
  typedef enum logic [3:0] {
    OP_NONE = 4'h1,
    OP_MOVE = 4'h2,
    OP_LOAD_AREG = 4'h4,
    OP_FLAGS_RW = 4'h8
  } mfd_op_t;
endpackage : mfd_pkg

// *** hw/mfd_decode.sv ***
/*
  combinational decoder of one move-family opcode: class, size, legality,
  target register number and operand width.
  assumes the opcode is stable for the whole cycle in which it is read.
*/
`timescale 1ns/1ps
`default_nettype none
module mfd_decode (
  input wire logic [15:0] opcode_in,
  output logic is_move_out,
  output logic is_load_areg_out,
  output logic is_flags_read_out,
  output logic is_flags_write_out,
  output logic illegal_out,
  output logic [1:0] size_out,
  output logic [2:0] dst_reg_out
);
  import mfd_pkg::*;

  // destination of data-alterable kind: no address reg, pc-relative or immediate
  function automatic logic data_alterable(input logic [2:0] mode, input logic [2:0] rg);
    data_alterable = (mode == MODE_DREG) || (mode >= MODE_IND_LO && mode <= MODE_IND_HI)
      || (mode == MODE_EXT && (rg == EXT_ABS_W || rg == EXT_ABS_L));
  endfunction : data_alterable

  function automatic logic any_mode(input logic [2:0] mode, input logic [2:0] rg);
    any_mode = (mode != MODE_EXT) || (rg <= EXT_IMM);
  endfunction : any_mode

  wire logic [2:0] src_mode = opcode_in[5:3];
  wire logic [2:0] src_reg = opcode_in[2:0];
  wire logic [2:0] dst_mode = opcode_in[8:6];
  wire logic [1:0] sz = opcode_in[13:12];
  wire logic top_move = (opcode_in[15:14] == TOP_MOVE) && (sz != 2'h0);
  wire logic load_areg = top_move && (dst_mode == MODE_AREG);
  wire logic gen_move = top_move && !load_areg;
  wire logic flags_read = (opcode_in[15:6] == OPC_FROM_FLAGS);
  wire logic flags_write = (opcode_in[15:6] == OPC_TO_FLAGS);
  // RULE1 move destination check
  wire logic move_dst_ok = data_alterable(dst_mode, opcode_in[11:9]);
  // RULE2 all move sources
  // RULE3 byte from address reg
  wire logic move_src_ok = any_mode(src_mode, src_reg) && !(sz == SZ_BYTE && src_mode == MODE_AREG);
  // RULE5 word or long only
  // RULE6 all sources accepted
  wire logic load_ok = any_mode(src_mode, src_reg) && (sz != SZ_BYTE);
  // RULE8 flags read destination
  wire logic fread_ok = data_alterable(src_mode, src_reg);
  // RULE14 flags write data source
  wire logic fwrite_ok = any_mode(src_mode, src_reg) && (src_mode != MODE_AREG);

  assign is_move_out = gen_move;
  assign is_load_areg_out = load_areg;
  assign is_flags_read_out = flags_read;
  assign is_flags_write_out = flags_write;
  // RULE15 illegal combination flagged
  assign illegal_out = !(gen_move && move_dst_ok && move_src_ok)
    && !(load_areg && load_ok) && !(flags_read && fread_ok) && !(flags_write && fwrite_ok);
  // RULE13 size field decode
  // RULE9 flag ops use word width
  assign size_out = (flags_read || flags_write) ? SZ_WORD : sz;
  // RULE4 dedicated destination field
  assign dst_reg_out = opcode_in[11:9];
endmodule : mfd_decode
`default_nettype wire

// *** bench/mfd_master.sv ***
/*
  ahb-lite master model standing in for the core's operand path: single
  whole-word transfers. assumes the only slave's hreadyout is fed back as hready.
*/
`timescale 1ns/1ps
`default_nettype none
module mfd_master (
  input wire logic clk_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_in,
  output logic hsel_out,
  output logic [31:0] haddr_out,
  output logic [1:0] htrans_out,
  output logic hwrite_out,
  output logic [2:0] hsize_out,
  output logic [31:0] hwdata_out
);
  initial
  begin
    hsel_out = 1'b0;
    haddr_out = 32'h00000000;
    htrans_out = 2'h0;
    hwrite_out = 1'b0;
    hsize_out = 3'h2;
    hwdata_out = 32'h00000000;
  end

  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel_out <= 1'b1;
    haddr_out <= {24'h000000, a};
    htrans_out <= 2'h2;
    hwrite_out <= w;
    hsize_out <= 3'h2;
    // idle data line toggles so a stale value is never mistaken for data
    hwdata_out <= ~hwdata_out;
    @(posedge clk_in);
    while (hready_in !== 1'b1) @(posedge clk_in);
    hsel_out <= 1'b0;
    htrans_out <= 2'h0;
    hwdata_out <= d;
    @(posedge clk_in);
    while (hready_in !== 1'b1) @(posedge clk_in);
    q = hrdata_in;
  endtask : xfer
endmodule : mfd_master
`default_nettype wire

// *** bench/move_family_decode_tb.sv ***
/*
  self-checking bench: table of opcodes run through the execute unit,
  then interrupt and reset cases. assumes mfd_core and mfd_master.
*/
`timescale 1ns/1ps
`default_nettype none
module move_family_decode_tb;
  import mfd_pkg::*;
  typedef struct packed {
    logic [15:0] op;
    logic [31:0] src;
    logic [31:0] res;
    logic [4:0] fl;
    logic [7:0] st;
  } mfd_row_t;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic hsel, hwrite, hready, hresp, illegal, irq;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int num_errors = 0;
  int tests_run = 0;
  int ill_cnt = 0;
  int ill_prev;
  // st 0 marks an illegal row; st 8'h80 a flag op (only the class nibble checked)
  mfd_row_t rows [16] = '{
    '{16'h44fc, 32'h0000ff1f, 32'h0, 5'h1f, 8'h80},
    '{16'h1600, 32'h12345680, 32'h80, 5'h18, 8'h23},
    '{16'h33ca, 32'hffff0000, 32'h0, 5'h14, 8'h21},
    '{16'h2bbc, 32'h80000001, 32'h80000001, 5'h18, 8'h25},
    '{16'h1008, 32'hffffffff, 32'h80000001, 5'h18, 8'h00},
    '{16'h39c0, 32'hffffffff, 32'h80000001, 5'h18, 8'h00},
    '{16'h35c0, 32'hffffffff, 32'h80000001, 5'h18, 8'h00},
    '{16'h3c7b, 32'h00008001, 32'hffff8001, 5'h18, 8'h46},
    '{16'h244f, 32'h00008001, 32'h00008001, 5'h18, 8'h42},
    '{16'h1240, 32'hffffffff, 32'h00008001, 5'h18, 8'h00},
    '{16'h42c1, 32'hffffffff, 32'h18, 5'h18, 8'h80},
    '{16'h42c9, 32'hffffffff, 32'h18, 5'h18, 8'h00},
    '{16'h42fc, 32'hffffffff, 32'h18, 5'h18, 8'h00},
    '{16'h44c8, 32'hffffffff, 32'h18, 5'h18, 8'h00},
    '{16'h0000, 32'hffffffff, 32'h18, 5'h18, 8'h00},
    '{16'h44c0, 32'h00000005, 32'h18, 5'h05, 8'h80}
  };

  mfd_core DUT (.clk_in(clk_in), .srst_in(srst_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .illegal_out(illegal), .irq_out(irq));
  mfd_master m (.clk_in(clk_in), .hready_in(hready), .hrdata_in(hrdata), .hsel_out(hsel),
    .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize),
    .hwdata_out(hwdata));

  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) if (illegal === 1'b1) ill_cnt <= ill_cnt + 1;

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [31:0] d);
    m.xfer(1'b1, a, d, q);
  endtask : wr

  task rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    m.xfer(1'b0, a, 32'h0, q);
    chk(nm, e, q);
    chk("hresp", 32'h0, {31'h0, hresp});
    chk("hready", 32'h1, {31'h0, hready});
  endtask : rdc

  // irq is decoded combinationally from the registered status bits, so let two edges land first
  task chk_irq(input logic e);
    repeat (2) @(posedge clk_in);
    #1;
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask : chk_irq

  task conclude;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude

  initial
  begin
    #100000;
    num_errors++;
    conclude();
  end

  initial
  begin
    repeat (2) @(posedge clk_in);
    srst_in <= 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      ill_prev = ill_cnt;
      wr(OFS_OPCODE, {16'h0000, rows[i].op});
      wr(OFS_SRC, rows[i].src);
      wr(OFS_CTRL, 32'h1);
      rdc(OFS_RESULT, rows[i].res, "result");
      rdc(OFS_STATE, {27'h0, rows[i].fl}, "state");
      chk("illegal", {31'h0, rows[i].st == 8'h00}, 32'(ill_cnt - ill_prev));
      rdc(OFS_IRQ_STAT, (rows[i].st == 8'h00) ? 32'h2 : 32'h1, "irq_stat");
      if (rows[i].st != 8'h00)
      begin
        m.xfer(1'b0, OFS_STATUS, 32'h0, q);
        if (rows[i].st[7])
          q[3:0] = 4'h0;
        chk("status", {24'h0, rows[i].st}, {24'h0, q[7:0]});
      end
      chk("irq_masked", 32'h0, {31'h0, irq});
      wr(OFS_IRQ_STAT, 32'h3);
    end
    // interrupt raised while masked, then unmasked, then cleared
    wr(OFS_OPCODE, 32'h00001008);
    wr(OFS_CTRL, 32'h1);
    chk_irq(1'b0);
    wr(OFS_IRQ_MASK, 32'h2);
    chk_irq(1'b1);
    rdc(OFS_IRQ_MASK, 32'h2, "irq_mask");
    wr(OFS_IRQ_STAT, 32'h2);
    chk_irq(1'b0);
    rdc(OFS_IRQ_STAT, 32'h0, "irq_stat_clr");
    // done event through the low mask bit
    wr(OFS_IRQ_MASK, 32'h1);
    wr(OFS_OPCODE, 32'h000044c0);
    wr(OFS_CTRL, 32'h1);
    chk_irq(1'b1);
    wr(OFS_IRQ_STAT, 32'h1);
    chk_irq(1'b0);
    // second reset in mid-run, then reset values and unmapped space
    srst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    srst_in <= 1'b0;
    rdc(OFS_RESULT, 32'h0, "result_rst");
    rdc(OFS_STATE, 32'h0, "state_rst");
    rdc(OFS_IRQ_MASK, 32'h0, "mask_rst");
    rdc(OFS_CTRL, 32'h0, "ctrl_rd");
    wr(8'h20, 32'hffffffff);
    rdc(8'h20, 32'h0, "unmapped");
    conclude();
  end
endmodule : move_family_decode_tb
`default_nettype wire
